// *** rtl/sbd_pkg.sv ***
// ============================================================
// Shared constants of the diagnostic readout block
package sbd_pkg;
	// ============================================================
	// Frame layout, least significant bit shifted first
	localparam int FRAME_W = 16;
	localparam int DATA_W = 10;
	localparam int MS_LSB = 0;
	localparam int CS_LSB = 3;
	localparam int DATA_LSB = 6;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] DECODE_BITS = 5'h05;

	// Mode selection codes
	typedef enum logic [2:0] {
		SBD_NORMAL = 3'b000,
		SBD_SLEEP = 3'b001,
		SBD_RESTART = 3'b010,
		SBD_FAILSAFE = 3'b011,
		SBD_INIT = 3'b100,
		SBD_READ_ONLY = 3'b111
	} sbd_mode_e;

	// Configuration select codes
	localparam logic [2:0] CS_WAKE = 3'h3;
	localparam logic [2:0] CS_CONFIG = 3'h4;
	localparam logic [2:0] CS_DIAG = 3'h7;

	// Field positions inside the data part
	localparam int CFG_FALLBACK_BIT = 5;
	localparam int CFG_WDCOUNT_BIT = 7;
	localparam int WAKE_LIVE_BIT = 9;
	localparam logic [DATA_W-1:0] CONFIG_RST = 10'h080;
	localparam logic [DATA_W-1:0] STORE_RST = 10'h000;

	// Fallback cause codes
	localparam logic [2:0] CAUSE_NONE = 3'h0;
	localparam logic [2:0] CAUSE_UV = 3'h1;
	localparam logic [2:0] CAUSE_WD1 = 3'h2;
	localparam logic [2:0] CAUSE_WD2 = 3'h3;
	localparam logic [2:0] CAUSE_INIT = 3'h4;
	localparam logic [2:0] CAUSE_THERM = 3'h5;
	localparam logic [2:0] CAUSE_CLAMP = 3'h6;
	localparam logic [2:0] CAUSE_RSVD = 3'h7;

	// Restart reason codes
	localparam logic [1:0] REASON_NONE = 2'h0;
	localparam logic [1:0] REASON_WD = 2'h2;
	localparam logic [1:0] REASON_SW = 2'h3;

	// ============================================================
	// Register bus map and status bits
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_STATUS = 12'h000;
	localparam logic [11:0] OFS_MASK = 12'h004;
	localparam logic [11:0] OFS_DIAG = 12'h008;
	localparam logic [11:0] OFS_MODE = 12'h00C;
	localparam int ST_W = 4;
	localparam int ST_FRAME = 0;
	localparam int ST_RO = 1;
	localparam int ST_BAD = 2;
	localparam int ST_FALLBACK = 3;
	localparam logic [3:0] ST_RST = 4'h0;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam logic [4:0] PIN_RST = 5'h02;
endpackage

// *** rtl/sbd_spi_diag.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// How it works
// - fallback cause is a 3-bit code, 000 none, listed causes ascending, 111 reserved.
// - cause returns to 000 when a frame switches the fallback output off.
// - 3-bit strap readout shows strap config, test pin, watchdog count setting.
// - top bit 0: low bits pick restart/fail-safe after one/two failures.
// - top bit 1: watchdog failure keeps supply, no reset, no mode change.
// - non read-only frames answer with the last non read-only frame's request.
// - first frame after Normal echoes prior mode; wake or fallback register.
// - from init or requested restart, first frame returns configuration register.
// - the automatic first frame never clears reported status bits.
// - read-only frame writes nothing and keeps the current mode.
// - read-only frame clears latched wake bits or restart reason of selected register, not live bits or cause.
// - read-only frame returns the selected register within the same frame.
// - read-only frame still triggers the watchdog like any complete frame.
// - restart reason clears on read-only read and leaving sleep/fail-safe.
module sbd_spi_diag (
	// Clock and reset
	input wire logic MCLK_IN,
	input wire logic RESETN_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [sbd_pkg::ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Serial link and strap pins
	input wire logic SCLK_IN,
	input wire logic CSN_IN,
	input wire logic SDI_IN,
	output logic SDO_OUT,
	output logic SDO_OE_OUT,
	input wire logic CFG_STRAP_IN,
	input wire logic TEST_PIN_IN,
	// Events from the rest of the device, same clock
	input wire logic WDOG_FAIL_IN,
	input wire logic FALLBACK_EVT_IN,
	input wire logic [2:0] FALLBACK_CODE_IN,
	input wire logic RESTART_EVT_IN,
	input wire logic [1:0] RESTART_CODE_IN,
	input wire logic [8:0] WAKE_EVT_IN,
	input wire logic WAKE_LEVEL_IN,
	// Device control outputs
	output logic FALLBACK_OUT,
	output logic WD_TRIGGER_OUT,
	output logic RESET_REQ_OUT,
	output logic SUPPLY_OFF_OUT,
	output logic [2:0] MODE_OUT,
	output logic IRQ_OUT
);
	import sbd_pkg::*;

	logic [4:0] pin_q;
	logic sclk_d, csn_d, rise, fall, frame_start, frame_end, dec_q;
	logic [4:0] bit_cnt;
	logic [FRAME_W-1:0] rx_sh, tx_sh, resp;
	logic [1:0] strap_cnt;
	logic strap_cfg, strap_test;
	logic [DATA_W-1:0] store [0:7];
	logic [2:0] cause;
	logic [1:0] reason;
	logic [8:0] wake_flags;
	logic restart_failure, wd_cnt;
	sbd_mode_e mode, next_mode;
	logic [ST_W-1:0] status, mask;
	logic frame_ok, frame_bad, is_ro, wd_react, wd_first, activate;
	logic entry, lh_off, apb_wr, apb_setup;
	logic [2:0] f_ms, f_cs, first_cs, strap_rd;
	logic [DATA_W-1:0] f_data;

	// ============================================================
	// Pin synchronisers and link edge finding
	sbd_sync #(.W(5), .RST(PIN_RST)) u_sync (
		.clk_in(MCLK_IN),
		.rst_n_in(RESETN_IN),
		.d_in({TEST_PIN_IN, CFG_STRAP_IN, SDI_IN, CSN_IN, SCLK_IN}),
		.q_out(pin_q)
	);

	// Delayed copies give one-cycle edge pulses
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			sclk_d <= 1'b0;
			csn_d <= 1'b1;
		end else begin
			sclk_d <= pin_q[0];
			csn_d <= pin_q[1];
		end
	end
	assign rise = pin_q[0] & ~sclk_d & ~pin_q[1];
	assign fall = ~pin_q[0] & sclk_d & ~pin_q[1];
	assign frame_start = csn_d & ~pin_q[1];
	assign frame_end = ~csn_d & pin_q[1];

	// Straps are caught once the synchroniser has settled
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			strap_cnt <= 2'h0;
			strap_cfg <= 1'b0;
			strap_test <= 1'b0;
		end else if (strap_cnt != STRAP_WAIT) begin
			strap_cnt <= strap_cnt + 2'h1;
			strap_cfg <= pin_q[3];
			strap_test <= pin_q[4];
		end
	end
	assign strap_rd = {strap_test, store[CS_CONFIG][CFG_WDCOUNT_BIT],
		strap_cfg};

	// ============================================================
	// Register readout shared by pipelined and same-frame answers
	function automatic logic [DATA_W-1:0] read_data(input logic [2:0] cs);
		unique case (cs)
			CS_DIAG: read_data = {2'h0, reason, strap_rd, cause};
			CS_WAKE: read_data = {WAKE_LEVEL_IN, wake_flags};
			default: read_data = store[cs];
		endcase
	endfunction

	// ============================================================
	// Serial shift logic
	assign f_ms = rx_sh[MS_LSB+:3];
	assign f_cs = rx_sh[CS_LSB+:3];
	assign f_data = rx_sh[DATA_LSB+:DATA_W];
	assign frame_ok = frame_end && bit_cnt == FRAME_BITS;
	assign frame_bad = frame_end && bit_cnt != FRAME_BITS;
	assign is_ro = f_ms == SBD_READ_ONLY;

	// receive LSB first, newest bit enters at the top
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rx_sh <= '0;
			bit_cnt <= 5'h0;
			dec_q <= 1'b0;
		end else begin
			dec_q <= rise && bit_cnt == DECODE_BITS;
			if (frame_start) begin
				bit_cnt <= 5'h0;
			end else if (rise) begin
				rx_sh <= {pin_q[2], rx_sh[FRAME_W-1:1]};
				if (bit_cnt != 5'h1F) begin
					bit_cnt <= bit_cnt + 5'h1;
				end
			end
		end
	end

	// Transmit: six header bits go out before the command is known
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			tx_sh <= '0;
		end else if (frame_start) begin
			tx_sh <= resp;
		end else if (dec_q && rx_sh[FRAME_W-6+:3] == SBD_READ_ONLY) begin
			// After six bits the mode field sits six places below the top
			// same-frame answer replaces the unsent data bits
			tx_sh[DATA_W:1] <= read_data(rx_sh[FRAME_W-3+:3]);
		end else if (fall) begin
			tx_sh <= {1'b0, tx_sh[FRAME_W-1:1]};
		end
	end
	assign SDO_OUT = tx_sh[0];
	assign SDO_OE_OUT = ~pin_q[1];

	// ============================================================
	// Watchdog reaction
	assign wd_first = WDOG_FAIL_IN && !strap_rd[2] && strap_rd[1] && !wd_cnt;
	// one or two failures, restart or fail-safe
	assign wd_react = WDOG_FAIL_IN && !strap_rd[2] && !wd_first;
	assign activate = wd_react || FALLBACK_EVT_IN;

	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			wd_cnt <= 1'b0;
		end else if (wd_first) begin
			wd_cnt <= 1'b1;
		end else if (wd_react || frame_ok) begin
			wd_cnt <= 1'b0;
		end
	end

	// ============================================================
	// Mode control
	assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
	always_comb begin
		next_mode = mode;
		if (wd_react) begin
			next_mode = strap_cfg ? SBD_FAILSAFE : SBD_RESTART;
		end else if (wd_first) begin
			next_mode = SBD_RESTART;
		end else if (frame_ok && !is_ro) begin
			// of the frames, only write frames may change the mode
			if (f_ms <= 3'h4) begin
				next_mode = sbd_mode_e'(f_ms);
			end
		end else if (apb_wr && PADDR_IN == OFS_MODE) begin
			if (PWDATA_IN[2:0] <= 3'h4) begin
				next_mode = sbd_mode_e'(PWDATA_IN[2:0]);
			end
		end
	end
	assign entry = next_mode == SBD_NORMAL && mode != SBD_NORMAL;

	// Mode and the failure flag that steers the first answer
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			mode <= SBD_INIT;
			restart_failure <= 1'b0;
			RESET_REQ_OUT <= 1'b0;
		end else begin
			mode <= next_mode;
			RESET_REQ_OUT <= (wd_react && !strap_cfg) || wd_first;
			if (wd_react || wd_first) begin
				restart_failure <= 1'b1;
			end else if (next_mode == SBD_RESTART && mode != SBD_RESTART) begin
				restart_failure <= 1'b0;
			end
		end
	end
	assign MODE_OUT = mode;
	assign SUPPLY_OFF_OUT = mode == SBD_FAILSAFE;

	// first frame register by previous mode
	always_comb begin
		unique case (mode)
			SBD_SLEEP: first_cs = CS_WAKE;
			SBD_FAILSAFE: first_cs = CS_DIAG;
			SBD_RESTART: first_cs = restart_failure ? CS_DIAG : CS_CONFIG;
			// init and requested restart give configuration
			default: first_cs = CS_CONFIG;
		endcase
	end

	// ============================================================
	// Pending answer for the next frame
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			resp <= '0;
		end else if (entry) begin
			// loading the first answer clears nothing
			resp <= {read_data(first_cs), first_cs, mode};
		end else if (frame_ok && !is_ro) begin
			// answer the request one frame late
			resp <= {read_data(f_cs), f_cs, mode};
		end
	end

	// ============================================================
	// Stored registers written by frames
	assign lh_off = frame_ok && !is_ro && f_cs == CS_CONFIG &&
		!f_data[CFG_FALLBACK_BIT];
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			for (int i = 0; i < 8; i++) begin
				store[i] <= (i == CS_CONFIG) ? CONFIG_RST : STORE_RST;
			end
		end else begin
			if (frame_ok && !is_ro && f_cs != CS_DIAG) begin
				store[f_cs] <= f_data;
			end
			if (activate) begin
				store[CS_CONFIG][CFG_FALLBACK_BIT] <= 1'b1;
			end
		end
	end
	assign FALLBACK_OUT = store[CS_CONFIG][CFG_FALLBACK_BIT];

	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			cause <= CAUSE_NONE;
		end else if (wd_react) begin
			cause <= strap_rd[1] ? CAUSE_WD2 : CAUSE_WD1;
		end else if (FALLBACK_EVT_IN) begin
			cause <= FALLBACK_CODE_IN;
		end else if (lh_off) begin
			cause <= CAUSE_NONE;
		end
	end

	// reason clears on read or leaving sleep or fail-safe
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			reason <= REASON_NONE;
		end else if (RESTART_EVT_IN) begin
			reason <= RESTART_CODE_IN;
		end else if (wd_first) begin
			reason <= REASON_WD;
		end else if (frame_ok && f_ms == SBD_RESTART) begin
			reason <= REASON_SW;
		end else if ((frame_ok && is_ro && f_cs == CS_DIAG) ||
			((mode == SBD_SLEEP || mode == SBD_FAILSAFE) &&
			next_mode != mode)) begin
			reason <= REASON_NONE;
		end
	end

	// latched wake bits clear on read, the live bit is not stored
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			wake_flags <= 9'h000;
		end else if (frame_ok && is_ro && f_cs == CS_WAKE) begin
			wake_flags <= WAKE_EVT_IN;
		end else begin
			wake_flags <= wake_flags | WAKE_EVT_IN;
		end
	end

	// every complete frame triggers the watchdog
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			WD_TRIGGER_OUT <= 1'b0;
		end else begin
			WD_TRIGGER_OUT <= frame_ok;
		end
	end

	// ============================================================
	// APB slave, zero wait, answer prepared in the setup cycle
	assign apb_setup = PSEL_IN && !PENABLE_IN;
	assign PREADY_OUT = 1'b1;
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			PRDATA_OUT <= 32'h0000_0000;
			PSLVERR_OUT <= 1'b0;
		end else if (apb_setup) begin
			PSLVERR_OUT <= 1'b0;
			unique case (PADDR_IN)
				OFS_STATUS: PRDATA_OUT <= {28'h0, status};
				OFS_MASK: PRDATA_OUT <= {28'h0, mask};
				OFS_DIAG: PRDATA_OUT <= {21'h0, mode, reason, strap_rd, cause};
				OFS_MODE: PRDATA_OUT <= {29'h0, mode};
				default: begin
					PRDATA_OUT <= 32'h0000_0000;
					PSLVERR_OUT <= 1'b1;
				end
			endcase
		end
	end

	// Sticky events, write one to clear, a new event wins
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			status <= ST_RST;
			mask <= ST_RST;
		end else begin
			status <= (status & ~((apb_wr && PADDR_IN == OFS_STATUS) ?
				PWDATA_IN[ST_W-1:0] : 4'h0)) |
				{activate, frame_bad, frame_ok && is_ro, frame_ok};
			if (apb_wr && PADDR_IN == OFS_MASK) begin
				mask <= PWDATA_IN[ST_W-1:0];
			end
		end
	end
	assign IRQ_OUT = |(status & mask);

	// ============================================================
	// Checks
	sequence s_sleep_entry;
		mode == SBD_SLEEP && next_mode == SBD_NORMAL;
	endsequence
	sequence s_ro_frame;
		frame_ok && is_ro && !wd_react && !wd_first;
	endsequence

	property p_cause_off;
		@(posedge MCLK_IN) disable iff (!RESETN_IN)
		lh_off && !activate |=> cause == CAUSE_NONE;
	endproperty
	a_cause_off: assert property (p_cause_off)
		else $error("cause not cleared on switch-off");

	property p_ro_mode;
		@(posedge MCLK_IN) disable iff (!RESETN_IN)
		s_ro_frame |=> mode == $past(mode) && resp == $past(resp);
	endproperty
	a_ro_mode: assert property (p_ro_mode)
		else $error("read-only frame changed mode or answer");

	property p_wd_trig;
		@(posedge MCLK_IN) disable iff (!RESETN_IN)
		frame_ok |=> WD_TRIGGER_OUT ##1 !WD_TRIGGER_OUT;
	endproperty
	a_wd_trig: assert property (p_wd_trig)
		else $error("frame gave no single trigger pulse");

	property p_wake_clear;
		@(posedge MCLK_IN) disable iff (!RESETN_IN)
		s_ro_frame and (f_cs == CS_WAKE && WAKE_EVT_IN == 9'h0)
		|=> wake_flags == 9'h0;
	endproperty
	a_wake_clear: assert property (p_wake_clear)
		else $error("wake bits not cleared by read-only");

	property p_reason_clear;
		@(posedge MCLK_IN) disable iff (!RESETN_IN)
		s_ro_frame and (f_cs == CS_DIAG && !RESTART_EVT_IN)
		|=> reason == REASON_NONE;
	endproperty
	a_reason_clear: assert property (p_reason_clear)
		else $error("reason not cleared by read-only");

	property p_dev_mode;
		@(posedge MCLK_IN) disable iff (!RESETN_IN)
		WDOG_FAIL_IN && strap_rd[2] |=> !RESET_REQ_OUT;
	endproperty
	a_dev_mode: assert property (p_dev_mode)
		else $error("reset requested in development mode");

	property p_first_sleep;
		@(posedge MCLK_IN) disable iff (!RESETN_IN)
		s_sleep_entry |=> resp[5:0] == {CS_WAKE, SBD_SLEEP};
	endproperty
	a_first_sleep: assert property (p_first_sleep)
		else $error("wrong first answer after sleep");

	property p_pipe;
		@(posedge MCLK_IN) disable iff (!RESETN_IN)
		frame_ok && !is_ro && !entry |=> resp[5:3] == $past(f_cs);
	endproperty
	a_pipe: assert property (p_pipe)
		else $error("answer not taken from previous request");

	// The pending answer leaves with its lowest bit first
	property p_first_bit;
		@(posedge MCLK_IN) disable iff (!RESETN_IN)
		frame_start |=> SDO_OE_OUT && SDO_OUT == $past(resp[0]);
	endproperty
	a_first_bit: assert property (p_first_bit)
		else $error("first answer bit not on the serial output");
endmodule
`default_nettype wire

// *** rtl/sbd_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Two-stage synchroniser for pins from outside the clock domain
module sbd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta <= RST;
			q_out <= RST;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule
`default_nettype wire

// *** sim/sbc_spi_diag_readout_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench of the diagnostic readout block
module sbc_spi_diag_readout_tb;
	import sbd_pkg::*;
	// Straps low with two-failure default: restart on the first failure and again on the second
	localparam logic [2:0] STRAP_EXP = 3'h2;
	logic clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, sclk, cs_n, sdi, sdo, sdo_oe;
	logic wd_fail = 1'b0, fb_evt = 1'b0, rs_evt = 1'b0, wake_lvl = 1'b0;
	logic test_pin = 1'b0;
	logic [2:0] fb_code = 3'h0, mode;
	logic [1:0] rs_code = 2'h0;
	logic [8:0] wake_evt = 9'h000;
	logic fb, wd_trig, rst_req, sup_off, irq;
	logic [15:0] lfsr = 16'h6F56;
	int errors = 0, num_checks = 0, wd_cnt = 0, rst_cnt = 0;

	sbd_spi_diag i_sbd_spi_diag (
		.MCLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .SCLK_IN(sclk), .CSN_IN(cs_n),
		.SDI_IN(sdi), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe),
		.CFG_STRAP_IN(1'b0), .TEST_PIN_IN(test_pin), .WDOG_FAIL_IN(wd_fail),
		.FALLBACK_EVT_IN(fb_evt), .FALLBACK_CODE_IN(fb_code),
		.RESTART_EVT_IN(rs_evt), .RESTART_CODE_IN(rs_code),
		.WAKE_EVT_IN(wake_evt), .WAKE_LEVEL_IN(wake_lvl),
		.FALLBACK_OUT(fb), .WD_TRIGGER_OUT(wd_trig),
		.RESET_REQ_OUT(rst_req), .SUPPLY_OFF_OUT(sup_off),
		.MODE_OUT(mode), .IRQ_OUT(irq)
	);
	sbd_spi_master i_sbd_spi_master (
		.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
		.sdo_in(sdo), .sdo_oe_in(sdo_oe)
	);

	// ============================================================
	// Clock, pulse counters and run limit
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Count one-cycle pulses so their number can be compared later
	always @(posedge clk) begin
		if (wd_trig === 1'b1) wd_cnt++;
		if (rst_req === 1'b1) rst_cnt++;
	end
	// Whole run far below this; a hang ends here as a failure
	initial begin
		#300000;
		errors++;
		$display("Error at %0t: run timed out", $time);
		close_out();
	end

	// ============================================================
	// Helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] frame_word(input logic [2:0] m,
		input logic [2:0] s, input logic [9:0] d);
		return {d, s, m};
	endfunction
	function automatic logic [9:0] diag_data(input logic [1:0] r,
		input logic [2:0] c);
		return {2'h0, r, STRAP_EXP, c};
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("Mismatches %0d of %0d checks", errors, num_checks);
		if (errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One APB transfer: setup, then access held until pready
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// Callers look at outputs only after the access edge has settled
		@(negedge clk);
		if (pready !== 1'b1) begin
			errors++;
			$display("Error at %0t: no bus answer", $time);
			close_out();
		end
	endtask
	// Frame, then room for the device to act on it
	task automatic spi(input logic [2:0] m, input logic [2:0] s,
		input logic [9:0] d, output logic [15:0] rx);
		i_sbd_spi_master.xfer(frame_word(m, s, d), rx);
		repeat (10) @(posedge clk);
	endtask
	// Frame whose answer select and data fields are compared
	task automatic spi_chk(input logic [2:0] m, input logic [2:0] s,
		input logic [9:0] d, input logic [2:0] es, input logic [9:0] ed);
		logic [15:0] rx;
		spi(m, s, d, rx);
		check({19'h0, rx[15:3]}, {19'h0, ed, es});
	endtask
	task automatic pulse_fb(input logic [2:0] c);
		@(posedge clk);
		fb_evt <= 1'b1;
		fb_code <= c;
		@(posedge clk);
		fb_evt <= 1'b0;
	endtask

	// ============================================================
	// Main sequence
	initial begin
		logic [31:0] rd;
		logic [15:0] rx;
		logic [8:0] w;
		int c;
		int n0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		// Unmapped place is refused and reads zero
		apb(1'b0, 12'h010, 32'h0, rd);
		check({31'h0, pslverr}, 32'h1);
		check(rd, 32'h0);
		apb(1'b0, OFS_DIAG, 32'h0, rd);
		check(rd, {21'h0, SBD_INIT, 8'(diag_data(REASON_NONE, CAUSE_NONE))});
		// Leave init for normal; the next answer is the first frame
		spi(SBD_NORMAL, CS_CONFIG, CONFIG_RST, rx);
		check({29'h0, mode}, {29'h0, SBD_NORMAL});
		spi(SBD_NORMAL, CS_DIAG, 10'h000, rx);
		check({16'h0, rx}, {16'h0, frame_word(SBD_INIT, CS_CONFIG, CONFIG_RST)});
		lfsr = lfsr_next(lfsr);
		n0 = wd_cnt;
		// Read-only header still carries the pending answer's select
		spi_chk(SBD_READ_ONLY, CS_CONFIG, lfsr[9:0], CS_DIAG, CONFIG_RST);
		check(32'(wd_cnt - n0), 32'h1);
		check({29'h0, mode}, {29'h0, SBD_NORMAL});
		spi_chk(SBD_NORMAL, CS_CONFIG, CONFIG_RST, CS_DIAG, diag_data(REASON_NONE, CAUSE_NONE));
		// Latched wake events beside a live level
		lfsr = lfsr_next(lfsr);
		w = lfsr[8:0] | 9'h001;
		@(posedge clk);
		wake_evt <= w;
		wake_lvl <= 1'b1;
		@(posedge clk);
		wake_evt <= 9'h000;
		repeat (4) @(posedge clk);
		spi_chk(SBD_READ_ONLY, CS_WAKE, lfsr[15:6], CS_CONFIG, {1'b1, w});
		spi_chk(SBD_READ_ONLY, CS_WAKE, 10'h000, CS_CONFIG, 10'h200);
		spi_chk(SBD_READ_ONLY, CS_CONFIG, 10'h000, CS_CONFIG, CONFIG_RST);
		// Sticky status, then cleared by writing ones
		apb(1'b0, OFS_STATUS, 32'h0, rd);
		check(rd, 32'h3);
		apb(1'b1, OFS_STATUS, 32'hF, rd);
		apb(1'b0, OFS_STATUS, 32'h0, rd);
		check(rd, 32'h0);
		// Every fallback cause; the last one with its interrupt masked
		apb(1'b1, OFS_MASK, 32'h8, rd);
		for (c = 1; c < 7; c++) begin
			if (c == 6) begin
				apb(1'b1, OFS_MASK, 32'h0, rd);
			end
			pulse_fb(c[2:0]);
			apb(1'b0, OFS_DIAG, 32'h0, rd);
			check({29'h0, rd[2:0]}, 32'(c));
			check({30'h0, fb, irq}, {30'h0, 1'b1, c != 6});
			apb(1'b1, OFS_STATUS, 32'h8, rd);
			check({31'h0, irq}, 32'h0);
			spi(SBD_NORMAL, CS_CONFIG, CONFIG_RST, rx);
			apb(1'b0, OFS_DIAG, 32'h0, rd);
			check({28'h0, fb, rd[2:0]}, {28'h0, 1'b0, CAUSE_NONE});
		end
		// First watchdog failure: restart with supply kept, reset pulse
		n0 = rst_cnt;
		@(posedge clk);
		wd_fail <= 1'b1;
		@(posedge clk);
		wd_fail <= 1'b0;
		repeat (6) @(posedge clk);
		check({28'h0, sup_off, mode}, {28'h0, 1'b0, SBD_RESTART});
		check(32'(rst_cnt - n0), 32'h1);
		spi_chk(SBD_READ_ONLY, CS_DIAG, 10'h000, CS_CONFIG, diag_data(REASON_WD, CAUSE_NONE));
		apb(1'b0, OFS_DIAG, 32'h0, rd);
		check({30'h0, rd[7:6]}, {30'h0, REASON_NONE});
		// First answers after a failure restart and after sleep
		spi(SBD_NORMAL, CS_CONFIG, CONFIG_RST, rx);
		apb(1'b1, OFS_MODE, {29'h0, SBD_SLEEP}, rd);
		spi(SBD_NORMAL, CS_CONFIG, CONFIG_RST, rx);
		check({16'h0, rx}, {16'h0, frame_word(SBD_RESTART, CS_DIAG,
			diag_data(REASON_NONE, CAUSE_NONE))});
		spi(SBD_NORMAL, CS_CONFIG, CONFIG_RST, rx);
		check({16'h0, rx},
			{16'h0, frame_word(SBD_SLEEP, CS_WAKE, 10'h200)});
		// Second reset with the test pin high: development straps
		@(posedge clk);
		rst_n <= 1'b0;
		test_pin <= 1'b1;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		apb(1'b0, OFS_DIAG, 32'h0, rd);
		check(rd, {21'h0, SBD_INIT, 2'h0, 3'h6, CAUSE_NONE});
		n0 = rst_cnt;
		@(posedge clk);
		wd_fail <= 1'b1;
		@(posedge clk);
		wd_fail <= 1'b0;
		repeat (6) @(posedge clk);
		check({28'h0, sup_off, mode}, {28'h0, 1'b0, SBD_INIT});
		check(32'(rst_cnt - n0), 32'h0);
		close_out();
	end
endmodule
`default_nettype wire

// *** sim/sbd_spi_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Microcontroller acting as serial master, mode 0, 160 ns clock
module sbd_spi_master (
	// Link pins driven by the master
	output logic sclk_out,
	output logic cs_n_out,
	output logic sdi_out,
	// Answer from the device
	input wire logic sdo_in,
	input wire logic sdo_oe_in
);
	// Idle levels follow the pin pulls: clock and data low, select high
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
	end

	// One whole frame; a bit seen while the device floats its output is X
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		int i;
		cs_n_out = 1'b0;
		#200;
		for (i = 0; i < 16; i++) begin
			sdi_out = tx[i];
			#80 sclk_out = 1'b1;
			rx[i] = sdo_oe_in ? sdo_in : 1'bx;
			#80 sclk_out = 1'b0;
		end
		#80 cs_n_out = 1'b1;
		sdi_out = 1'b0;
		#160;
	endtask
endmodule
`default_nettype wire
